// file: pkg/ssp_pkg.sv
package ssp_pkg;
   localparam int WORD_W = 24;
   localparam int SEL_W = 4;

   // Latch numbers carried in the trailing select field
   localparam logic [3:0] SEL_BASE = 4'h0;
   localparam logic [3:0] SEL_CONFIG = 4'h1;
   localparam logic [3:0] SEL_FASTLOCK = 4'h2;

   // Configuration latch layout
   localparam int CFG_PWR_LSB = 4;
   localparam int PWR_W = 4;
   localparam int CFG_ORDER_LSB = 8;
   localparam int CFG_GP_LSB = 10;
   localparam int CFG_MUX_LSB = 12;
   localparam int MUX_W = 4;

   // Fastlock latch layout
   localparam int FL_EN_BIT = 4;
   localparam int FL_TMO_LSB = 8;
   localparam int FL_TMO_W = 8;
   localparam int FL_NORM_LSB = 16;
   localparam int FL_FAST_LSB = 20;
   localparam int FILT_W = 4;

   localparam logic [WORD_W-1:0] RST_LATCH = 24'h000000;

   typedef enum logic [1:0]
   {
      GP_FASTLOCK = 2'h0,
      GP_DRIVE_LOW = 2'h1,
      GP_RELEASE = 2'h2,
      GP_SPARE = 2'h3
   } ssp_gp_mode_t;

   typedef enum logic [1:0]
   {
      FL_IDLE = 2'b01,
      FL_RUN = 2'b10
   } ssp_fl_state_t;

   localparam logic [3:0] MUX_LOCK = 4'h0;
   localparam logic [3:0] MUX_FASTLOCK = 4'h1;
   localparam logic [3:0] MUX_CHIP_EN = 4'h2;
   localparam logic [3:0] MUX_ARMED = 4'h3;

   // Wishbone byte addresses
   localparam logic [7:0] ADR_STATUS = 8'h00;
   localparam logic [7:0] ADR_MASK = 8'h04;
   localparam logic [7:0] ADR_CTRL = 8'h08;
   localparam logic [7:0] ADR_STATE = 8'h0c;
   localparam logic [1:0] ADR_LATCH_PAGE = 2'h1;

   localparam int IRQ_W = 5;
   localparam int IRQ_LATCHED = 0;
   localparam int IRQ_LOCK_GAIN = 1;
   localparam int IRQ_LOCK_LOSS = 2;
   localparam int IRQ_FL_DONE = 3;
   localparam int IRQ_CE_RISE = 4;
   localparam logic [4:0] RST_MASK = 5'h00;

   localparam int CTRL_LOAD_EN_BIT = 0;
   localparam logic [0:0] RST_CTRL = 1'h1;
endpackage : ssp_pkg

// file: hdl/ssp_pin_sync.sv
`timescale 1ns/1ps
module ssp_pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic i_clken,
   input wire logic [WIDTH-1:0] i_pins,
   output logic [WIDTH-1:0] o_level
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   // Stage1 feeds stage2 only; a bit moves once stage2 and stage3 agree
   always_ff @(posedge i_clock)
   begin
      if (!i_resetn)
      begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
         o_level <= '0;
      end
      else if (i_clken)
      begin
         stage1 <= i_pins;
         stage2 <= stage1;
         stage3 <= stage2;
         o_level <= (~(stage2 ^ stage3) & stage3) | ((stage2 ^ stage3) & o_level);
      end
   end
endmodule : ssp_pin_sync

// file: hdl/ssp_top.sv
`timescale 1ns/1ps
// Function
// - Shift serial data in on every rising serial clock edge.
// - Words arrive most significant bit first.
// - Last bits shifted in select the destination latch.
// - Rising latch strobe copies shift register into selected latch.
// - Chip enable powers only sections marked in power bits.
// - After chip enable rises, lock waits for a base register rewrite.
// - Open-drain output for fastlock switch or general purpose.
// - Multiplexed push-pull output includes lock detect.
// - Modulator order programmable, up to fourth order.
// - Fastlock mode ends by a timeout counter.
// - Fastlock applies separate loop filter settings.
module ssp_top #(
   parameter int WORD_W = ssp_pkg::WORD_W,
   parameter int SEL_W = ssp_pkg::SEL_W
) (
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic i_clken,
   input wire logic i_serial_clock,
   input wire logic i_serial_data,
   input wire logic i_latch_load_strobe,
   input wire logic i_chip_enable,
   input wire logic i_loop_locked,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   output logic o_irq,
   output logic [ssp_pkg::PWR_W-1:0] o_power_en,
   output logic [2:0] o_mod_order,
   output logic [ssp_pkg::FILT_W-1:0] o_filter_setting,
   output logic o_fastlock_active,
   output logic o_fastlock_gp_output,
   output logic o_fastlock_gp_output_oe,
   output logic o_test_lock_detect_output
);
   localparam int NLATCH = 2 ** SEL_W;

   logic [4:0] pins_sync;
   logic sclk_s;
   logic sdat_s;
   logic strobe_s;
   logic ce_s;
   logic locked_s;
   logic sclk_d;
   logic strobe_d;
   logic ce_d;
   logic sclk_rise;
   logic strobe_rise;
   logic ce_rise;
   logic [WORD_W-1:0] shift_reg;
   logic [WORD_W-1:0] latch_mem [NLATCH];
   logic [SEL_W-1:0] last_sel;
   logic load_en;
   logic word_load;
   logic base_write;
   logic lock_armed;
   logic lock_detect;
   logic lock_detect_d;
   ssp_pkg::ssp_fl_state_t fl_state;
   logic [ssp_pkg::FL_TMO_W-1:0] fl_count;
   logic fl_done;
   logic [ssp_pkg::IRQ_W-1:0] irq_status;
   logic [ssp_pkg::IRQ_W-1:0] irq_mask;
   logic [ssp_pkg::IRQ_W-1:0] irq_event;
   logic wb_req;
   logic wb_wr;
   logic [31:0] next_rdata;

   function automatic logic [31:0] wb_lanes(input logic [31:0] data, input logic [3:0] sel);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 4; i++)
      begin
         m[i*8 +: 8] = sel[i] ? data[i*8 +: 8] : 8'h00;
      end
      return m;
   endfunction : wb_lanes

   ssp_pin_sync #(
      .WIDTH(5)
   ) u_sync (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .i_clken(i_clken),
      .i_pins({i_loop_locked, i_chip_enable, i_latch_load_strobe, i_serial_data,
         i_serial_clock}),
      .o_level(pins_sync)
   );

   assign sclk_s = pins_sync[0];
   assign sdat_s = pins_sync[1];
   assign strobe_s = pins_sync[2];
   assign ce_s = pins_sync[3];
   assign locked_s = pins_sync[4];

   always_ff @(posedge i_clock)
   begin
      if (!i_resetn)
      begin
         sclk_d <= 1'b0;
         strobe_d <= 1'b0;
         ce_d <= 1'b0;
      end
      else if (i_clken)
      begin
         sclk_d <= sclk_s;
         strobe_d <= strobe_s;
         ce_d <= ce_s;
      end
   end

   assign sclk_rise = sclk_s & ~sclk_d;
   assign strobe_rise = strobe_s & ~strobe_d;
   assign ce_rise = ce_s & ~ce_d;

   // msb enters first, ends on top
   always_ff @(posedge i_clock)
   begin
      if (!i_resetn)
      begin
         shift_reg <= '0;
      end
      else if (i_clken && sclk_rise)
      begin
         shift_reg <= {shift_reg[WORD_W-2:0], sdat_s};
      end
   end

   // Software may freeze loads while it inspects the latches
   assign word_load = strobe_rise & load_en;
   assign base_write = word_load & (shift_reg[SEL_W-1:0] == SEL_W'(ssp_pkg::SEL_BASE));

   always_ff @(posedge i_clock)
   begin
      if (!i_resetn)
      begin
         for (int i = 0; i < NLATCH; i++)
         begin
            latch_mem[i] <= ssp_pkg::RST_LATCH;
         end
         last_sel <= '0;
      end
      else if (i_clken && word_load)
      begin
         latch_mem[shift_reg[SEL_W-1:0]] <= shift_reg;
         last_sel <= shift_reg[SEL_W-1:0];
      end
   end

   // lock stays down until base rewrite; the rewrite wins a tie
   always_ff @(posedge i_clock)
   begin
      if (!i_resetn)
      begin
         lock_armed <= 1'b0;
      end
      else if (i_clken)
      begin
         if (base_write)
         begin
            lock_armed <= 1'b1;
         end
         else if (ce_rise)
         begin
            lock_armed <= 1'b0;
         end
      end
   end

   assign lock_detect = locked_s & lock_armed & ce_s;

   // power only what the bits allow
   // order code 0..3 means first to fourth order
   always_ff @(posedge i_clock)
   begin
      if (!i_resetn)
      begin
         o_power_en <= '0;
         o_mod_order <= 3'h1;
      end
      else if (i_clken)
      begin
         o_power_en <= ce_s ? latch_mem[ssp_pkg::SEL_CONFIG][ssp_pkg::CFG_PWR_LSB +: ssp_pkg::PWR_W]
            : '0;
         o_mod_order <= {1'b0, latch_mem[ssp_pkg::SEL_CONFIG][ssp_pkg::CFG_ORDER_LSB +: 2]} + 3'h1;
      end
   end

   // timeout counter ends fastlock; base write starts it
   always_ff @(posedge i_clock)
   begin
      if (!i_resetn)
      begin
         fl_state <= ssp_pkg::FL_IDLE;
         fl_count <= '0;
         fl_done <= 1'b0;
      end
      else if (i_clken)
      begin
         fl_done <= 1'b0;
         case (fl_state)
            ssp_pkg::FL_IDLE:
            begin
               if (base_write && latch_mem[ssp_pkg::SEL_FASTLOCK][ssp_pkg::FL_EN_BIT]
                  && latch_mem[ssp_pkg::SEL_FASTLOCK][ssp_pkg::FL_TMO_LSB +: ssp_pkg::FL_TMO_W]
                  != '0)
               begin
                  fl_state <= ssp_pkg::FL_RUN;
                  fl_count <= latch_mem[ssp_pkg::SEL_FASTLOCK][ssp_pkg::FL_TMO_LSB +:
                     ssp_pkg::FL_TMO_W];
               end
            end
            ssp_pkg::FL_RUN:
            begin
               // Dropping chip enable abandons fastlock without a done event
               if (!ce_s)
               begin
                  fl_state <= ssp_pkg::FL_IDLE;
                  fl_count <= '0;
               end
               else if (fl_count == ssp_pkg::FL_TMO_W'(1))
               begin
                  fl_state <= ssp_pkg::FL_IDLE;
                  fl_count <= '0;
                  fl_done <= 1'b1;
               end
               else
               begin
                  fl_count <= fl_count - ssp_pkg::FL_TMO_W'(1);
               end
            end
            default:
            begin
               fl_state <= ssp_pkg::FL_IDLE;
               fl_count <= '0;
            end
         endcase
      end
   end

   // separate filter code while fastlock runs
   // open drain: only ever pulls low
   // mux with lock detect as source zero
   always_ff @(posedge i_clock)
   begin
      if (!i_resetn)
      begin
         o_fastlock_active <= 1'b0;
         o_filter_setting <= '0;
         o_fastlock_gp_output <= 1'b0;
         o_fastlock_gp_output_oe <= 1'b0;
         o_test_lock_detect_output <= 1'b0;
         lock_detect_d <= 1'b0;
      end
      else if (i_clken)
      begin
         o_fastlock_active <= (fl_state == ssp_pkg::FL_RUN);
         o_filter_setting <= (fl_state == ssp_pkg::FL_RUN)
            ? latch_mem[ssp_pkg::SEL_FASTLOCK][ssp_pkg::FL_FAST_LSB +: ssp_pkg::FILT_W]
            : latch_mem[ssp_pkg::SEL_FASTLOCK][ssp_pkg::FL_NORM_LSB +: ssp_pkg::FILT_W];
         o_fastlock_gp_output <= 1'b0;
         case (ssp_pkg::ssp_gp_mode_t'(latch_mem[ssp_pkg::SEL_CONFIG][ssp_pkg::CFG_GP_LSB +: 2]))
            ssp_pkg::GP_FASTLOCK: o_fastlock_gp_output_oe <= (fl_state == ssp_pkg::FL_RUN);
            ssp_pkg::GP_DRIVE_LOW: o_fastlock_gp_output_oe <= 1'b1;
            default: o_fastlock_gp_output_oe <= 1'b0;
         endcase
         case (latch_mem[ssp_pkg::SEL_CONFIG][ssp_pkg::CFG_MUX_LSB +: ssp_pkg::MUX_W])
            ssp_pkg::MUX_LOCK: o_test_lock_detect_output <= lock_detect;
            ssp_pkg::MUX_FASTLOCK: o_test_lock_detect_output <= (fl_state == ssp_pkg::FL_RUN);
            ssp_pkg::MUX_CHIP_EN: o_test_lock_detect_output <= ce_s;
            ssp_pkg::MUX_ARMED: o_test_lock_detect_output <= lock_armed;
            default: o_test_lock_detect_output <= 1'b0;
         endcase
         lock_detect_d <= lock_detect;
      end
   end

   assign irq_event[ssp_pkg::IRQ_LATCHED] = word_load;
   assign irq_event[ssp_pkg::IRQ_LOCK_GAIN] = lock_detect & ~lock_detect_d;
   assign irq_event[ssp_pkg::IRQ_LOCK_LOSS] = ~lock_detect & lock_detect_d;
   assign irq_event[ssp_pkg::IRQ_FL_DONE] = fl_done;
   assign irq_event[ssp_pkg::IRQ_CE_RISE] = ce_rise;

   assign wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
   // Writes commit on the edge where the master sees ack, not earlier
   assign wb_wr = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack;

   // Set wins over a write-one clear in the same cycle
   always_ff @(posedge i_clock)
   begin
      if (!i_resetn)
      begin
         irq_status <= '0;
         irq_mask <= ssp_pkg::RST_MASK;
         load_en <= ssp_pkg::RST_CTRL[0];
      end
      else if (i_clken)
      begin
         if (wb_wr && i_wb_adr == ssp_pkg::ADR_STATUS)
         begin
            irq_status <= (irq_status & ~ssp_pkg::IRQ_W'(wb_lanes(i_wb_dat, i_wb_sel)))
               | irq_event;
         end
         else
         begin
            irq_status <= irq_status | irq_event;
         end
         if (wb_wr && i_wb_adr == ssp_pkg::ADR_MASK && i_wb_sel[0])
         begin
            irq_mask <= i_wb_dat[ssp_pkg::IRQ_W-1:0];
         end
         if (wb_wr && i_wb_adr == ssp_pkg::ADR_CTRL && i_wb_sel[0])
         begin
            load_en <= i_wb_dat[ssp_pkg::CTRL_LOAD_EN_BIT];
         end
      end
   end

   assign o_irq = |(irq_status & irq_mask);

   always_comb
   begin
      next_rdata = 32'h00000000;
      if (i_wb_adr[7:6] == ssp_pkg::ADR_LATCH_PAGE)
      begin
         if (int'(i_wb_adr[5:2]) < NLATCH)
         begin
            next_rdata = 32'(latch_mem[i_wb_adr[2 +: SEL_W]]);
         end
      end
      else
      begin
         case (i_wb_adr)
            ssp_pkg::ADR_STATUS: next_rdata = 32'(irq_status);
            ssp_pkg::ADR_MASK: next_rdata = 32'(irq_mask);
            ssp_pkg::ADR_CTRL: next_rdata = 32'(load_en);
            ssp_pkg::ADR_STATE: next_rdata = {20'h00000, 4'(last_sel), 3'h0, lock_detect,
               lock_armed, (fl_state == ssp_pkg::FL_RUN), ce_s, strobe_s};
            default: next_rdata = 32'h00000000;
         endcase
      end
   end

   // One-cycle answer; unmapped words read zero and ignore writes
   always_ff @(posedge i_clock)
   begin
      if (!i_resetn)
      begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= '0;
      end
      else if (i_clken)
      begin
         o_wb_ack <= wb_req;
         if (wb_req && !i_wb_we)
         begin
            o_wb_dat <= next_rdata;
         end
      end
   end

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_resetn);

   chk_shift_order: assert property ((i_clken && sclk_rise) |=>
      shift_reg == {$past(shift_reg[WORD_W-2:0]), $past(sdat_s)})
      else $error("shift register did not take data msb first");
   chk_latch_select: assert property ((i_clken && word_load) |=>
      latch_mem[$past(shift_reg[SEL_W-1:0])] == $past(shift_reg))
      else $error("selected latch not loaded from shift register");
   chk_power_gate: assert property ((i_clken && !ce_s) |=> o_power_en == '0)
      else $error("sections powered while chip enable low");
   chk_relock_wait: assert property ((i_clken && ce_rise && !base_write) |=>
      !lock_armed ##1 (!o_test_lock_detect_output || !(latch_mem[ssp_pkg::SEL_CONFIG]
      [ssp_pkg::CFG_MUX_LSB +: ssp_pkg::MUX_W] == ssp_pkg::MUX_LOCK) || lock_armed))
      else $error("lock shown before base register rewrite");
   chk_open_drain: assert property (!o_fastlock_gp_output)
      else $error("open drain output driven high");
   chk_mux_lock: assert property ((i_clken && latch_mem[ssp_pkg::SEL_CONFIG]
      [ssp_pkg::CFG_MUX_LSB +: ssp_pkg::MUX_W] == ssp_pkg::MUX_LOCK) |=>
      o_test_lock_detect_output == $past(lock_detect))
      else $error("mux output does not follow lock detect");
   chk_mod_order: assert property (o_mod_order >= 3'h1 && o_mod_order <= 3'h4)
      else $error("modulator order out of range");
   chk_fl_count: assert property ((i_clken && fl_state == ssp_pkg::FL_RUN && ce_s
      && fl_count > ssp_pkg::FL_TMO_W'(1)) |=> fl_count == $past(fl_count) - 8'h01
      && fl_state == ssp_pkg::FL_RUN)
      else $error("fastlock timeout counter did not count down");
   chk_fl_filter: assert property ((i_clken && fl_state == ssp_pkg::FL_RUN) |=>
      o_fastlock_active && o_filter_setting == $past(latch_mem[ssp_pkg::SEL_FASTLOCK]
      [ssp_pkg::FL_FAST_LSB +: ssp_pkg::FILT_W]))
      else $error("fastlock filter setting not applied");
   chk_wb_ack: assert property ((i_clken && wb_req) |=> o_wb_ack ##1 !o_wb_ack || !i_clken)
      else $error("wishbone ack not a single cycle");

   cov_word_load: cover property (i_clken && word_load);
   cov_fl_done: cover property (i_clken && fl_done);
   cov_relock: cover property (ce_rise ##[1:400] base_write ##[1:400] lock_detect);
endmodule : ssp_top

// file: sim/ssp_host_model.sv
`timescale 1ns/1ps
module ssp_host_model (
   input wire logic i_clock,
   output logic o_serial_clock,
   output logic o_serial_data,
   output logic o_latch_load_strobe
);
   // Link clock idles low between words
   initial
   begin
      o_serial_clock = 1'b0;
      o_serial_data = 1'b0;
      o_latch_load_strobe = 1'b0;
   end

   // Half period of four system cycles gives the 64 ns link clock
   task automatic send_word(input logic [ssp_pkg::WORD_W-1:0] word);
      int i;
      @(posedge i_clock);
      for (i = ssp_pkg::WORD_W - 1; i >= 0; i--)
      begin
         o_serial_data <= word[i];
         repeat (4) @(posedge i_clock);
         o_serial_clock <= 1'b1;
         repeat (4) @(posedge i_clock);
         o_serial_clock <= 1'b0;
      end
      repeat (4) @(posedge i_clock);
      o_serial_data <= ~word[0];
      o_latch_load_strobe <= 1'b1;
      repeat (8) @(posedge i_clock);
      o_latch_load_strobe <= 1'b0;
      repeat (8) @(posedge i_clock);
   endtask : send_word
endmodule : ssp_host_model

// file: sim/tb_synth_serial_program_port.sv
`timescale 1ns/1ps
module tb_synth_serial_program_port;
   logic i_clock = 1'b0;
   logic i_resetn = 1'b0;
   logic sclk, sdat, strobe;
   logic i_chip_enable = 1'b0;
   logic i_loop_locked = 1'b0;
   logic clken = 1'b1;
   logic [3:0] wsel = 4'hf;
   logic i_wb_cyc = 1'b0;
   logic i_wb_stb = 1'b0;
   logic i_wb_we = 1'b0;
   logic [7:0] i_wb_adr = 8'h00;
   logic [3:0] i_wb_sel = 4'h0;
   logic [31:0] i_wb_dat = 32'h00000000;
   logic [31:0] o_wb_dat, rd;
   logic o_wb_ack, o_irq, fl_act, gp_out, gp_oe, test_out;
   logic [3:0] pwr, filt;
   logic [2:0] order;
   int fail_count = 0;
   int tests_run = 0;
   int cycles = 0;
   int fl_cycles = 0;

   always #4 i_clock = ~i_clock;

   ssp_host_model u_host (
      .i_clock(i_clock),
      .o_serial_clock(sclk),
      .o_serial_data(sdat),
      .o_latch_load_strobe(strobe)
   );

   ssp_top u_dut (
      .i_clock(i_clock), .i_resetn(i_resetn), .i_clken(clken),
      .i_serial_clock(sclk), .i_serial_data(sdat), .i_latch_load_strobe(strobe),
      .i_chip_enable(i_chip_enable), .i_loop_locked(i_loop_locked),
      .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
      .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
      .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_irq(o_irq),
      .o_power_en(pwr), .o_mod_order(order), .o_filter_setting(filt),
      .o_fastlock_active(fl_act), .o_fastlock_gp_output(gp_out),
      .o_fastlock_gp_output_oe(gp_oe), .o_test_lock_detect_output(test_out)
   );

   always @(posedge i_clock)
   begin
      cycles <= cycles + 1;
      if (fl_act === 1'b1)
         fl_cycles <= fl_cycles + 1;
      if (cycles == 30000)
      begin
         fail_count = fail_count + 1;
         conclude();
      end
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         fail_count++;
      end
   endtask : check

   // Request held until ack is sampled, then one idle cycle
   task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                           output logic [31:0] q);
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we <= we;
      i_wb_adr <= adr;
      i_wb_sel <= wsel;
      i_wb_dat <= dat;
      @(posedge i_clock);
      while (o_wb_ack !== 1'b1)
         @(posedge i_clock);
      q = o_wb_dat;
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
      i_wb_we <= 1'b0;
      @(posedge i_clock);
   endtask : wb_cycle

   task automatic wb_write(input logic [7:0] adr, input logic [31:0] dat);
      logic [31:0] q;
      wb_cycle(1'b1, adr, dat, q);
   endtask : wb_write

   task automatic wb_read_check(input string what, input logic [7:0] adr,
                                input logic [31:0] exp);
      logic [31:0] q;
      wb_cycle(1'b0, adr, 32'h00000000, q);
      check(what, exp, q);
   endtask : wb_read_check

   task automatic settle();
      repeat (12) @(posedge i_clock);
   endtask : settle

   initial
   begin
      repeat (2) @(posedge i_clock);
      i_resetn <= 1'b1;
      repeat (6) @(posedge i_clock);
      wb_read_check("status", ssp_pkg::ADR_STATUS, 32'h00000000);
      wb_read_check("mask", ssp_pkg::ADR_MASK, 32'h00000000);
      wb_read_check("ctrl", ssp_pkg::ADR_CTRL, 32'h00000001);
      check("order", 32'h00000001, {29'h0, order});
      wb_read_check("unmapped", 8'h20, 32'h00000000);
      // Config: mux chip enable, gp pull low, order code 3, power 4'ha
      u_host.send_word(24'h0027a1);
      settle();
      wb_read_check("latch1", 8'h44, 32'h000027a1);
      check("order4", 32'h00000004, {29'h0, order});
      check("gp_oe", 32'h00000001, {31'h0, gp_oe});
      check("gp_out", 32'h00000000, {31'h0, gp_out});
      check("power_off", 32'h00000000, {28'h0, pwr});
      check("irq_masked", 32'h00000000, {31'h0, o_irq});
      wb_write(ssp_pkg::ADR_MASK, 32'h00000001);
      check("irq_on", 32'h00000001, {31'h0, o_irq});
      wb_write(ssp_pkg::ADR_STATUS, 32'h00000001);
      check("irq_clr", 32'h00000000, {31'h0, o_irq});
      i_chip_enable <= 1'b1;
      i_loop_locked <= 1'b1;
      settle();
      check("power_on", 32'h0000000a, {28'h0, pwr});
      check("mux_ce", 32'h00000001, {31'h0, test_out});
      // Mux to lock detect; no base write since chip enable rose
      u_host.send_word(24'h0007a1);
      settle();
      check("ld_disarmed", 32'h00000000, {31'h0, test_out});
      u_host.send_word(24'h123450);
      settle();
      check("ld_locked", 32'h00000001, {31'h0, test_out});
      wb_read_check("latch0", 8'h40, 32'h00123450);
      // Frozen block ignores the lock drop until the enable returns
      clken <= 1'b0;
      i_loop_locked <= 1'b0;
      settle();
      check("ld_frozen", 32'h00000001, {31'h0, test_out});
      clken <= 1'b1;
      settle();
      check("ld_lost", 32'h00000000, {31'h0, test_out});
      i_loop_locked <= 1'b1;
      settle();
      check("ld_regain", 32'h00000001, {31'h0, test_out});
      // Fastlock latch: fast filter 9, normal 3, timeout 16, enabled
      u_host.send_word(24'h931012);
      settle();
      check("filt_norm", 32'h00000003, {28'h0, filt});
      // Config: mux fastlock, gp follows fastlock, order code 3, power 4'ha
      u_host.send_word(24'h0013a1);
      settle();
      check("gp_idle", 32'h00000000, {31'h0, gp_oe});
      fl_cycles = 0;
      fork
         u_host.send_word(24'h123450);
         begin
            while (fl_act !== 1'b1)
               @(posedge i_clock);
            @(posedge i_clock);
            check("filt_fast", 32'h00000009, {28'h0, filt});
            check("mux_fl", 32'h00000001, {31'h0, test_out});
            check("gp_fl", 32'h00000001, {31'h0, gp_oe});
         end
      join
      settle();
      settle();
      check("fl_len", 32'd16, fl_cycles);
      check("filt_back", 32'h00000003, {28'h0, filt});
      check("mux_fl_off", 32'h00000000, {31'h0, test_out});
      check("gp_fl_off", 32'h00000000, {31'h0, gp_oe});
      wb_read_check("status_ev", ssp_pkg::ADR_STATUS, 32'h0000001f);
      // No byte lanes enabled: the clear must not land
      wsel = 4'h0;
      wb_write(ssp_pkg::ADR_STATUS, 32'h0000001f);
      wsel = 4'hf;
      wb_read_check("status_nosel", ssp_pkg::ADR_STATUS, 32'h0000001f);
      wb_write(ssp_pkg::ADR_STATUS, 32'h0000001f);
      wb_read_check("status_clr", ssp_pkg::ADR_STATUS, 32'h00000000);
      wb_read_check("state", ssp_pkg::ADR_STATE, 32'h0000001a);
      // Loading disabled: strobe refused, shifting continues
      wb_write(ssp_pkg::ADR_CTRL, 32'h00000000);
      u_host.send_word(24'h555553);
      settle();
      wb_read_check("latch3", 8'h4c, 32'h00000000);
      wb_write(ssp_pkg::ADR_CTRL, 32'h00000001);
      i_chip_enable <= 1'b0;
      settle();
      check("power_down", 32'h00000000, {28'h0, pwr});
      conclude();
   end
endmodule : tb_synth_serial_program_port
